// ===== rtl/pll_ratio_strap_select.sv
module pll_ratio_strap_select #(
    parameter int MULT_W = clk_mode_pkg::MULT_W
) (
    input  wire logic                   clk_i,
    input  wire logic                   rstn_i,
    input  wire logic [5:0]             ratio_strap_i,
    input  wire logic                   dynamic_frequency_switching_i,
    input  wire logic [MULT_W-1:0]      dynamic_frequency_switching_half_i,
    input  wire logic                   bus_clock_qualifier_i,
    output logic                        pll_enable_o,
    output logic                        core_clock_enable_o,
    output logic                        core_from_reference_o,
    output logic                        bus_clock_enable_o,
    output logic [MULT_W-1:0]           bus_core_half_o,
    output logic [1:0]                  core_vco_mult_o,
    output logic                        strap_reserved_o,
    output logic                        acknowledge_delay_needed_o,
    output logic                        strap_valid_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Strap capture on the first edge after reset release.

    logic [5:0]                 strap_ff;
    logic                       captured_ff;
    logic [5:0]                 nxt_strap;
    logic                       nxt_captured;
    clk_mode_pkg::ratio_cfg_t   cfg;

    // Until capture the decoder sees the off code, so nothing is clocked.
    assign nxt_strap    = captured_ff ? strap_ff : ratio_strap_i;
    assign nxt_captured = 1'b1;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            strap_ff <= clk_mode_pkg::CODE_OFF;
        end
        else
        begin
            strap_ff <= nxt_strap;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            captured_ff <= 1'b0;
        end
        else
        begin
            captured_ff <= nxt_captured;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Code decode.

    ratio_decode ratio_decode_inst (
        .strap_i (strap_ff),
        .cfg_o   (cfg)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode.

    wire is_pll    = captured_ff && (cfg.mode == clk_mode_pkg::MODE_PLL);
    wire is_bypass = captured_ff && (cfg.mode == clk_mode_pkg::MODE_BYPASS);
    wire is_resv   = captured_ff && (cfg.mode == clk_mode_pkg::MODE_RESERVED);

    // Switching overrides the strap ratio only in PLL mode.
    wire [MULT_W-1:0] strap_half  = MULT_W'(cfg.bus_core_half);
    wire [MULT_W-1:0] switch_half = dynamic_frequency_switching_i ?
                                    dynamic_frequency_switching_half_i : strap_half;
    wire [MULT_W-1:0] eff_half    = is_pll ? switch_half : MULT_W'(clk_mode_pkg::HALF_NONE);

    ////////////////////////////////////////////////////////////////////////////
    // Next output values.

    wire              nxt_pll_enable        = is_pll;
    wire              nxt_core_from_ref     = is_bypass;
    // The off code and every reserved code leave the core unclocked.
    wire              nxt_core_clock_enable = is_pll || is_bypass;
    // In bypass the bus ticks on the qualifier, i.e. every second reference edge.
    wire              nxt_bus_clock_enable  = is_pll ||
                                              (is_bypass && bus_clock_qualifier_i);
    wire [MULT_W-1:0] nxt_bus_core_half     = eff_half;
    // The core-to-VCO ratio is reported only while the PLL runs.
    wire [1:0]        nxt_core_vco_mult     = is_pll ? cfg.core_vco_mult :
                                              clk_mode_pkg::VCO_MULT_NONE;
    wire              nxt_strap_reserved    = is_resv;
    // The acknowledge flag follows the effective ratio, switching included.
    wire              nxt_ack_delay         = is_pll &&
                                              (eff_half < clk_mode_pkg::HALF_5X);
    wire              nxt_strap_valid       = captured_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs.
    // Each output has its own flip-flop so downstream clock gating sees no glitch.

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pll_enable_o <= '0;
        end
        else
        begin
            pll_enable_o <= nxt_pll_enable;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            core_clock_enable_o <= '0;
        end
        else
        begin
            core_clock_enable_o <= nxt_core_clock_enable;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            core_from_reference_o <= '0;
        end
        else
        begin
            core_from_reference_o <= nxt_core_from_ref;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            bus_clock_enable_o <= '0;
        end
        else
        begin
            bus_clock_enable_o <= nxt_bus_clock_enable;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            bus_core_half_o <= '0;
        end
        else
        begin
            bus_core_half_o <= nxt_bus_core_half;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            core_vco_mult_o <= clk_mode_pkg::VCO_MULT_NONE;
        end
        else
        begin
            core_vco_mult_o <= nxt_core_vco_mult;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            strap_reserved_o <= '0;
        end
        else
        begin
            strap_reserved_o <= nxt_strap_reserved;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            acknowledge_delay_needed_o <= '0;
        end
        else
        begin
            acknowledge_delay_needed_o <= nxt_ack_delay;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            strap_valid_o <= '0;
        end
        else
        begin
            strap_valid_o <= nxt_strap_valid;
        end
    end

endmodule : pll_ratio_strap_select

// ===== rtl/clk_mode_pkg.sv
package clk_mode_pkg;

    localparam int          STRAP_W      = 6;
    // Multiplier expressed in half steps (value = 2 x multiplier).
    localparam int          MULT_W       = 7;

    localparam logic [5:0]  CODE_11X     = 6'h26;
    localparam logic [5:0]  CODE_11X5    = 6'h00;
    localparam logic [5:0]  CODE_12X     = 6'h2E;
    localparam logic [5:0]  CODE_12X5    = 6'h3E;
    localparam logic [5:0]  CODE_13X     = 6'h16;
    localparam logic [5:0]  CODE_13X5    = 6'h38;
    localparam logic [5:0]  CODE_14X     = 6'h32;
    localparam logic [5:0]  CODE_15X     = 6'h06;
    localparam logic [5:0]  CODE_16X     = 6'h36;
    localparam logic [5:0]  CODE_17X     = 6'h02;
    localparam logic [5:0]  CODE_18X     = 6'h0A;
    localparam logic [5:0]  CODE_20X     = 6'h0E;
    localparam logic [5:0]  CODE_21X     = 6'h12;
    localparam logic [5:0]  CODE_24X     = 6'h1A;
    localparam logic [5:0]  CODE_28X     = 6'h3A;
    localparam logic [5:0]  CODE_BYPASS  = 6'h0C;
    localparam logic [5:0]  CODE_OFF     = 6'h3C;

    localparam logic [6:0]  HALF_11X     = 7'h16;
    localparam logic [6:0]  HALF_11X5    = 7'h17;
    localparam logic [6:0]  HALF_12X     = 7'h18;
    localparam logic [6:0]  HALF_12X5    = 7'h19;
    localparam logic [6:0]  HALF_13X     = 7'h1A;
    localparam logic [6:0]  HALF_13X5    = 7'h1B;
    localparam logic [6:0]  HALF_14X     = 7'h1C;
    localparam logic [6:0]  HALF_15X     = 7'h1E;
    localparam logic [6:0]  HALF_16X     = 7'h20;
    localparam logic [6:0]  HALF_17X     = 7'h22;
    localparam logic [6:0]  HALF_18X     = 7'h24;
    localparam logic [6:0]  HALF_20X     = 7'h28;
    localparam logic [6:0]  HALF_21X     = 7'h2A;
    localparam logic [6:0]  HALF_24X     = 7'h30;
    localparam logic [6:0]  HALF_28X     = 7'h38;
    localparam logic [6:0]  HALF_NONE    = 7'h00;
    // Below 5x the bus system must stretch its address acknowledge.
    localparam logic [6:0]  HALF_5X      = 7'h0A;
    localparam logic [1:0]  VCO_MULT_1X  = 2'h1;
    localparam logic [1:0]  VCO_MULT_NONE = 2'h0;

    typedef enum logic [1:0] {
        MODE_PLL,
        MODE_BYPASS,
        MODE_OFF,
        MODE_RESERVED
    } clk_mode_t;

    typedef struct packed {
        clk_mode_t   mode;
        logic [6:0]  bus_core_half;
        logic [1:0]  core_vco_mult;
    } ratio_cfg_t;

endpackage : clk_mode_pkg

// ===== rtl/ratio_decode.sv
module ratio_decode (
    input  wire logic [5:0]             strap_i,
    output clk_mode_pkg::ratio_cfg_t    cfg_o
);

    always_comb
    begin
        cfg_o.mode          = clk_mode_pkg::MODE_PLL;
        cfg_o.core_vco_mult = clk_mode_pkg::VCO_MULT_1X;
        case (strap_i)
            clk_mode_pkg::CODE_11X:    cfg_o.bus_core_half = clk_mode_pkg::HALF_11X;
            clk_mode_pkg::CODE_11X5:   cfg_o.bus_core_half = clk_mode_pkg::HALF_11X5;
            clk_mode_pkg::CODE_12X:    cfg_o.bus_core_half = clk_mode_pkg::HALF_12X;
            clk_mode_pkg::CODE_12X5:   cfg_o.bus_core_half = clk_mode_pkg::HALF_12X5;
            clk_mode_pkg::CODE_13X:    cfg_o.bus_core_half = clk_mode_pkg::HALF_13X;
            clk_mode_pkg::CODE_13X5:   cfg_o.bus_core_half = clk_mode_pkg::HALF_13X5;
            clk_mode_pkg::CODE_14X:    cfg_o.bus_core_half = clk_mode_pkg::HALF_14X;
            clk_mode_pkg::CODE_15X:    cfg_o.bus_core_half = clk_mode_pkg::HALF_15X;
            clk_mode_pkg::CODE_16X:    cfg_o.bus_core_half = clk_mode_pkg::HALF_16X;
            clk_mode_pkg::CODE_17X:    cfg_o.bus_core_half = clk_mode_pkg::HALF_17X;
            clk_mode_pkg::CODE_18X:    cfg_o.bus_core_half = clk_mode_pkg::HALF_18X;
            clk_mode_pkg::CODE_20X:    cfg_o.bus_core_half = clk_mode_pkg::HALF_20X;
            clk_mode_pkg::CODE_21X:    cfg_o.bus_core_half = clk_mode_pkg::HALF_21X;
            clk_mode_pkg::CODE_24X:    cfg_o.bus_core_half = clk_mode_pkg::HALF_24X;
            clk_mode_pkg::CODE_28X:    cfg_o.bus_core_half = clk_mode_pkg::HALF_28X;
            clk_mode_pkg::CODE_BYPASS:
            begin
                cfg_o.mode          = clk_mode_pkg::MODE_BYPASS;
                cfg_o.bus_core_half = clk_mode_pkg::HALF_NONE;
                cfg_o.core_vco_mult = clk_mode_pkg::VCO_MULT_NONE;
            end
            clk_mode_pkg::CODE_OFF:
            begin
                cfg_o.mode          = clk_mode_pkg::MODE_OFF;
                cfg_o.bus_core_half = clk_mode_pkg::HALF_NONE;
                cfg_o.core_vco_mult = clk_mode_pkg::VCO_MULT_NONE;
            end
            default:
            begin
                cfg_o.mode          = clk_mode_pkg::MODE_RESERVED;
                cfg_o.bus_core_half = clk_mode_pkg::HALF_NONE;
                cfg_o.core_vco_mult = clk_mode_pkg::VCO_MULT_NONE;
            end
        endcase
    end

endmodule : ratio_decode

// ===== testbench/strap_board_model.sv
module strap_board_model (
    input  wire logic       clk_i,
    input  wire logic [5:0] code_i,
    output logic [5:0]      ratio_strap_o,
    output logic            bus_clock_qualifier_o
);
    timeunit 1ns;
    timeprecision 1ns;
    assign ratio_strap_o = code_i;
    initial bus_clock_qualifier_o = 1'b0;
    // Half the reference rate, moved half a period off the sampling edge.
    always @(negedge clk_i) bus_clock_qualifier_o <= ~bus_clock_qualifier_o;
endmodule : strap_board_model

// ===== testbench/pll_ratio_strap_select_properties.sv
module pll_ratio_strap_select_properties #(parameter int MULT_W = 7) (
    input wire logic              clk_i, rstn_i, dynamic_frequency_switching_i,
    input wire logic              bus_clock_qualifier_i, strap_valid_o,
    input wire logic [5:0]        ratio_strap_i,
    input wire logic [MULT_W-1:0] dynamic_frequency_switching_half_i, bus_core_half_o,
    input wire logic              pll_enable_o, core_clock_enable_o, core_from_reference_o,
    input wire logic              bus_clock_enable_o, strap_reserved_o, acknowledge_delay_needed_o,
    input wire logic [1:0]        core_vco_mult_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    chk_pll_outputs: assert property (pll_enable_o |-> core_vco_mult_o == 2'h1 && bus_clock_enable_o)
        else $error("pll mode outputs wrong");
    chk_bypass_core: assert property (core_from_reference_o |-> core_clock_enable_o && !pll_enable_o)
        else $error("bypass core clocking wrong");
    chk_bypass_bus: assert property (core_from_reference_o && $past(core_from_reference_o)
        |-> bus_clock_enable_o == $past(bus_clock_qualifier_i))
        else $error("bypass bus enable wrong");
    chk_off_quiet: assert property (!core_clock_enable_o |-> !bus_clock_enable_o && !pll_enable_o)
        else $error("clocking while stopped");
    chk_reserved_stop: assert property (strap_reserved_o |-> !core_clock_enable_o)
        else $error("reserved code clocks core");
    chk_switch_follow: assert property (pll_enable_o && $past(pll_enable_o)
        && $past(dynamic_frequency_switching_i)
        |-> bus_core_half_o == $past(dynamic_frequency_switching_half_i))
        else $error("switching multiplier not used");
    chk_ack_flag: assert property (acknowledge_delay_needed_o
        == (pll_enable_o && bus_core_half_o < clk_mode_pkg::HALF_5X))
        else $error("acknowledge flag wrong");
    chk_strap_kept: assert property (strap_valid_o && $past(strap_valid_o)
        |-> $stable(pll_enable_o) && $stable(core_from_reference_o) && $stable(strap_reserved_o))
        else $error("mode changed after capture");
    chk_valid_sticky: assert property (strap_valid_o |=> strap_valid_o)
        else $error("strap valid dropped");
    cover property (pll_enable_o && dynamic_frequency_switching_i);
    cover property (core_from_reference_o && bus_clock_enable_o);
    cover property (strap_reserved_o);
endmodule : pll_ratio_strap_select_properties
bind pll_ratio_strap_select pll_ratio_strap_select_properties #(.MULT_W(MULT_W)) props_inst (
    .clk_i, .rstn_i, .dynamic_frequency_switching_i, .bus_clock_qualifier_i, .strap_valid_o,
    .ratio_strap_i, .dynamic_frequency_switching_half_i, .bus_core_half_o, .pll_enable_o,
    .core_clock_enable_o,
    .core_from_reference_o, .bus_clock_enable_o, .strap_reserved_o, .acknowledge_delay_needed_o,
    .core_vco_mult_o);

// ===== testbench/pll_ratio_strap_select_bench.sv
module pll_ratio_strap_select_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk_i = 1'b0, rstn_i = 1'b0, switch_on = 1'b0, qual, pll, core_en, from_ref;
    logic       bus_en, rsv, ack, valid;
    logic [5:0] code = 6'h26, strap;
    logic [6:0] switch_half = 7'h00, half;
    logic [1:0] vco;
    int         err_total = 0, n_checks = 0;
    wire [15:0] outs = {pll, core_en, from_ref, rsv, ack, vco, valid, 1'b0, half};
    initial forever #4 clk_i = ~clk_i;
    strap_board_model strap_board_model_inst (.clk_i, .code_i(code), .ratio_strap_o(strap),
        .bus_clock_qualifier_o(qual));
    pll_ratio_strap_select pll_ratio_strap_select_inst (.clk_i, .rstn_i, .ratio_strap_i(strap),
        .dynamic_frequency_switching_i(switch_on),
        .dynamic_frequency_switching_half_i(switch_half),
        .bus_clock_qualifier_i(qual), .pll_enable_o(pll), .core_clock_enable_o(core_en),
        .core_from_reference_o(from_ref), .bus_clock_enable_o(bus_en), .bus_core_half_o(half),
        .core_vco_mult_o(vco), .strap_reserved_o(rsv), .acknowledge_delay_needed_o(ack),
        .strap_valid_o(valid));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop();
        if (err_total == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop
    task automatic start(input logic [5:0] c);
        int n;
        @(negedge clk_i);
        rstn_i = 1'b0;
        code = c;
        repeat (10) @(negedge clk_i);
        rstn_i = 1'b1;
        n = 0;
        while (valid !== 1'b1 && n < 4)
        begin
            @(negedge clk_i);
            n++;
        end
        check(16'(n), 16'h0002);
        if (n == 4)
            report_and_stop();
    endtask : start
    task automatic t_pll_table();
        logic [5:0] codes [15] = '{6'h26, 6'h00, 6'h2E, 6'h3E, 6'h16, 6'h38, 6'h32, 6'h06,
            6'h36, 6'h02, 6'h0A, 6'h0E, 6'h12, 6'h1A, 6'h3A};
        logic [6:0] halves [15] = '{7'h16, 7'h17, 7'h18, 7'h19, 7'h1A, 7'h1B, 7'h1C, 7'h1E,
            7'h20, 7'h22, 7'h24, 7'h28, 7'h2A, 7'h30, 7'h38};
        for (int i = 0; i < 15; i++)
        begin
            start(codes[i]);
            check(outs, {8'hC3, 1'b0, halves[i]});
        end
    endtask : t_pll_table
    task automatic t_bypass();
        logic q;
        start(6'h0C);
        check(outs, 16'h6100);
        repeat (4)
        begin
            @(posedge clk_i) q = qual;
            @(negedge clk_i) check(16'(bus_en), 16'(q));
        end
    endtask : t_bypass
    task automatic t_stopped();
        start(6'h3C);
        check({outs[15:1], bus_en}, 16'h0100);
        start(6'h01);
        check({outs[15:1], bus_en}, 16'h1100);
    endtask : t_stopped
    task automatic t_switching();
        start(6'h26);
        switch_on = 1'b1;
        switch_half = 7'h09;
        @(negedge clk_i) check(outs, 16'hCB09);
        switch_half = 7'h0A;
        @(negedge clk_i) check(outs, 16'hC30A);
        switch_on = 1'b0;
        @(negedge clk_i) check(outs, 16'hC316);
    endtask : t_switching
    task automatic t_hold();
        start(6'h3A);
        code = 6'h0C;
        repeat (3) @(negedge clk_i);
        check(outs, 16'hC338);
    endtask : t_hold
    initial
    begin
        t_pll_table();
        t_bypass();
        t_stopped();
        t_switching();
        t_hold();
        report_and_stop();
    end
    initial
    begin
        #100000;
        err_total++;
        report_and_stop();
    end
endmodule : pll_ratio_strap_select_bench
